// file: design/cmp_pkg.sv
package cmp_pkg;

	// Register indices as printed; byte address is four times the index
	localparam logic [7:0]  CMP_ONE_INDEX       = 8'hAC;
	localparam logic [7:0]  CMP_TWO_INDEX       = 8'hAD;
	localparam logic [11:0] CMP_ONE_ADDR        = {2'h0, CMP_ONE_INDEX, 2'h0};
	localparam logic [11:0] CMP_TWO_ADDR        = {2'h0, CMP_TWO_INDEX, 2'h0};
	// Interrupt and status block
	localparam logic [11:0] IRQ_STATUS_ADDR     = 12'h2C0;
	localparam logic [11:0] IRQ_CLEAR_ADDR      = 12'h2C4;
	localparam logic [11:0] IRQ_ENABLE_ADDR     = 12'h2C8;
	localparam int          ADDR_WIDTH          = 12;

	// Control register fields
	localparam int          ENABLE_BIT          = 5;
	localparam int          POS_SELECT_BIT      = 4;
	localparam int          NEG_SELECT_BIT      = 3;
	localparam int          PIN_OE_BIT          = 2;
	localparam int          SYNC_RESULT_BIT     = 1;
	localparam int          CHANGE_FLAG_BIT     = 0;
	localparam logic [7:0]  CONTROL_RESET       = 8'h00;
	localparam logic [1:0]  IRQ_ENABLE_RESET    = 2'h0;

	// Status register: change flags in [1:0], settled in [3:2]
	localparam int          STATUS_SETTLED_LSB  = 2;

	// Settling time after enable
	localparam int          CLOCK_MHZ           = 125;
	localparam int          SETTLE_TIME_US      = 10;
	localparam int          SETTLE_CYCLES       = SETTLE_TIME_US * CLOCK_MHZ;
	localparam int          SETTLE_WIDTH        = 11;

endpackage

// file: design/dual_comparator_control.sv
// The APB register port was decided locally.
`timescale 1ns/1ps
`default_nettype none

module dual_comparator_control #(
	parameter int SETTLE_COUNT = cmp_pkg::SETTLE_CYCLES
) (
	input  wire logic                            i_clock,
	input  wire logic                            i_rst_b,
	// APB slave
	input  wire logic                            i_psel,
	input  wire logic                            i_penable,
	input  wire logic                            i_pwrite,
	input  wire logic [cmp_pkg::ADDR_WIDTH-1:0]  i_paddr,
	input  wire logic [31:0]                     i_pwdata,
	output logic      [31:0]                     o_prdata,
	output logic                                 o_pready,
	output logic                                 o_pslverr,
	output logic                                 o_irq,
	// Analog comparator one
	input  wire logic                            i_comparator_one_raw,
	output logic                                 o_comparator_one_enable,
	output logic                                 o_comparator_one_positive_select,
	output logic                                 o_comparator_one_negative_select,
	output logic                                 o_comparator_one_control_and_pin,
	output logic                                 o_comparator_one_control_and_pin_oe,
	// Analog comparator two
	input  wire logic                            i_comparator_two_raw,
	output logic                                 o_comparator_two_enable,
	output logic                                 o_comparator_two_positive_select,
	output logic                                 o_comparator_two_negative_select,
	output logic                                 o_comparator_two_control_and_pin,
	output logic                                 o_comparator_two_control_and_pin_oe
);
	import cmp_pkg::*;

	localparam logic [SETTLE_WIDTH-1:0] SETTLE_LAST = SETTLE_WIDTH'(SETTLE_COUNT - 1);

	// Per-comparator state, index 0 = one, 1 = two
	logic [1:0]              enable;
	logic [1:0]              pos_select;
	logic [1:0]              neg_select;
	logic [1:0]              pin_oe;
	logic [1:0]              pin_drive;
	logic [1:0]              sync_result;
	logic [1:0]              change_flag;
	logic [1:0]              settled;
	logic [1:0]              irq_enable;
	logic [1:0]              raw;
	logic [1:0]              sync_a;
	logic [1:0]              sync_b;
	logic [1:0]              sync_c;
	logic [1:0]              next_sync_result;
	logic [1:0]              change_event;
	logic [1:0]              sw_clear;
	logic [1:0]              ctrl_write;
	logic [SETTLE_WIDTH-1:0] settle_count [2];

	// Bus decode
	logic                    access;
	logic                    do_write;
	logic                    hit_one;
	logic                    hit_two;
	logic                    hit_status;
	logic                    hit_clear;
	logic                    hit_enable;
	logic                    mapped;
	logic [31:0]             read_value;

	// Control register image as software sees it
	function automatic logic [7:0] control_image(input logic [1:0] sel_idx_onehot, input int idx);
		logic [7:0] v;
		v = 8'h00;
		v[ENABLE_BIT]      = enable[idx];
		v[POS_SELECT_BIT]  = pos_select[idx];
		v[NEG_SELECT_BIT]  = neg_select[idx];
		v[PIN_OE_BIT]      = pin_oe[idx];
		v[SYNC_RESULT_BIT] = sync_result[idx];
		v[CHANGE_FLAG_BIT] = change_flag[idx];
		return sel_idx_onehot[idx] ? v : 8'h00;
	endfunction

	// Address match against one register's byte address
	function automatic logic addr_hit(input logic [ADDR_WIDTH-1:0] addr, input logic [ADDR_WIDTH-1:0] target);
		return addr == target;
	endfunction

	assign raw         = {i_comparator_two_raw, i_comparator_one_raw};
	assign access      = i_psel && i_penable;
	assign do_write    = access && o_pready && i_pwrite;
	assign hit_one     = addr_hit(i_paddr, CMP_ONE_ADDR);
	assign hit_two     = addr_hit(i_paddr, CMP_TWO_ADDR);
	assign hit_status  = addr_hit(i_paddr, IRQ_STATUS_ADDR);
	assign hit_clear   = addr_hit(i_paddr, IRQ_CLEAR_ADDR);
	assign hit_enable  = addr_hit(i_paddr, IRQ_ENABLE_ADDR);
	assign mapped      = hit_one || hit_two || hit_status || hit_clear || hit_enable;
	assign ctrl_write  = {do_write && hit_two, do_write && hit_one};

	// Software clear: write 0 to flag bit, or 1 to clear register
	always_comb begin
		for (int i = 0; i < 2; i++) begin
			sw_clear[i] = (ctrl_write[i] && !i_pwdata[CHANGE_FLAG_BIT])
				|| (do_write && hit_clear && i_pwdata[i]);
		end
	end

	// Read multiplexer; unmapped and write-only addresses read zero
	always_comb begin
		read_value = 32'h0000_0000;
		if (hit_one) begin
			read_value[7:0] = control_image(2'h1, 0);
		end else if (hit_two) begin
			read_value[7:0] = control_image(2'h2, 1);
		end else if (hit_status) begin
			read_value[1:0] = change_flag;
			read_value[STATUS_SETTLED_LSB +: 2] = settled;
		end else if (hit_enable) begin
			read_value[1:0] = irq_enable;
		end
	end

	// APB ready: one wait state, answer in second access cycle
	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_pready <= 1'b0;
		end else begin
			o_pready <= access && !o_pready;
		end
	end

	// APB error for unmapped addresses, with ready
	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_pslverr <= 1'b0;
		end else begin
			o_pslverr <= access && !o_pready && !mapped;
		end
	end

	// APB read data, zero outside the answer cycle
	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_prdata <= 32'h0000_0000;
		end else begin
			o_prdata <= (access && !o_pready && !i_pwrite) ? read_value : 32'h0000_0000;
		end
	end

	// Comparator enables
	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			enable <= {2{CONTROL_RESET[ENABLE_BIT]}};
		end else begin
			for (int i = 0; i < 2; i++) begin
				if (ctrl_write[i]) begin
					enable[i] <= i_pwdata[ENABLE_BIT];
				end
			end
		end
	end

	// Positive input selects
	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			pos_select <= {2{CONTROL_RESET[POS_SELECT_BIT]}};
		end else begin
			for (int i = 0; i < 2; i++) begin
				if (ctrl_write[i]) begin
					pos_select[i] <= i_pwdata[POS_SELECT_BIT];
				end
			end
		end
	end

	// Negative input selects
	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			neg_select <= {2{CONTROL_RESET[NEG_SELECT_BIT]}};
		end else begin
			for (int i = 0; i < 2; i++) begin
				if (ctrl_write[i]) begin
					neg_select[i] <= i_pwdata[NEG_SELECT_BIT];
				end
			end
		end
	end

	// Pin output enables as written
	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			pin_oe <= {2{CONTROL_RESET[PIN_OE_BIT]}};
		end else begin
			for (int i = 0; i < 2; i++) begin
				if (ctrl_write[i]) begin
					pin_oe[i] <= i_pwdata[PIN_OE_BIT];
				end
			end
		end
	end

	// Pin drive gate kept in a flop so the enable output is glitch free
	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			pin_drive <= 2'h0;
		end else begin
			for (int i = 0; i < 2; i++) begin
				if (ctrl_write[i]) begin
					pin_drive[i] <= i_pwdata[ENABLE_BIT] && i_pwdata[PIN_OE_BIT];
				end
			end
		end
	end

	// Interrupt enable register
	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			irq_enable <= IRQ_ENABLE_RESET;
		end else if (do_write && hit_enable) begin
			irq_enable <= i_pwdata[1:0];
		end
	end

	// Three-stage synchroniser on the raw results
	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			sync_a <= 2'h0;
			sync_b <= 2'h0;
			sync_c <= 2'h0;
		end else begin
			sync_a <= raw;
			sync_b <= sync_a;
			sync_c <= sync_b;
		end
	end

	// Accept new level once last two stages agree; zero when disabled
	always_comb begin
		for (int i = 0; i < 2; i++) begin
			if (!enable[i]) begin
				next_sync_result[i] = 1'b0;
			end else if (sync_b[i] == sync_c[i]) begin
				next_sync_result[i] = sync_c[i];
			end else begin
				next_sync_result[i] = sync_result[i];
			end
			change_event[i] = enable[i] && (next_sync_result[i] != sync_result[i]);
		end
	end

	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			sync_result <= 2'h0;
		end else begin
			sync_result <= next_sync_result;
		end
	end

	// Sticky change flags; set beats software clear, disable clears
	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			change_flag <= 2'h0;
		end else begin
			for (int i = 0; i < 2; i++) begin
				if (!enable[i]) begin
					change_flag[i] <= 1'b0;
				end else if (change_event[i]) begin
					change_flag[i] <= 1'b1;
				end else if (sw_clear[i]) begin
					change_flag[i] <= 1'b0;
				end
			end
		end
	end

	// Settle timers restart whenever a comparator is off
	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			settle_count[0] <= '0;
			settle_count[1] <= '0;
		end else begin
			for (int i = 0; i < 2; i++) begin
				if (!enable[i]) begin
					settle_count[i] <= '0;
				end else if (!settled[i]) begin
					settle_count[i] <= settle_count[i] + 1'b1;
				end
			end
		end
	end

	// Settled once the timer reaches its last count
	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			settled <= 2'h0;
		end else begin
			for (int i = 0; i < 2; i++) begin
				if (!enable[i]) begin
					settled[i] <= 1'b0;
				end else if (!settled[i]) begin
					settled[i] <= (settle_count[i] == SETTLE_LAST);
				end
			end
		end
	end

	// Interrupt request from enabled flags
	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_irq <= 1'b0;
		end else begin
			o_irq <= |(change_flag & irq_enable);
		end
	end

	// Analog control outputs
	assign o_comparator_one_enable          = enable[0];
	assign o_comparator_two_enable          = enable[1];
	assign o_comparator_one_positive_select = pos_select[0];
	assign o_comparator_two_positive_select = pos_select[1];
	assign o_comparator_one_negative_select = neg_select[0];
	assign o_comparator_two_negative_select = neg_select[1];

	// Pin data bypasses the clock; the pin enable comes from the pin_drive flop
	assign o_comparator_one_control_and_pin_oe = pin_drive[0];
	assign o_comparator_two_control_and_pin_oe = pin_drive[1];
	assign o_comparator_one_control_and_pin    = i_comparator_one_raw && o_comparator_one_control_and_pin_oe;
	assign o_comparator_two_control_and_pin    = i_comparator_two_raw && o_comparator_two_control_and_pin_oe;

endmodule // dual_comparator_control

`default_nettype wire

// file: testbench/cmp_analog_model.sv
`timescale 1ns/1ps
`default_nettype none
module cmp_analog_model (
	input  wire logic i_clock,
	input  wire logic i_enable,
	input  wire logic i_pos,
	input  wire logic i_neg,
	input  var  int   i_a,
	input  var  int   i_b,
	input  var  int   i_ext,
	input  var  int   i_ref,
	output logic      o_raw
);
	logic wander = 1'h0;
	// Unpowered core output is unsettled
	always @(posedge i_clock) wander <= ~wander;
	// Input muxes and compare
	always_comb o_raw = i_enable ? ((i_pos ? i_b : i_a) > (i_neg ? i_ref : i_ext)) : wander;
endmodule // cmp_analog_model
`default_nettype wire

// file: testbench/dual_comparator_control_chk.sv
`timescale 1ns/1ps
`default_nettype none
module dual_comparator_control_chk (
	input wire logic        i_clock,
	input wire logic        i_rst_b,
	input wire logic        i_pwrite,
	input wire logic [11:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	input wire logic [31:0] o_prdata,
	input wire logic        o_pready,
	input wire logic        o_irq,
	input wire logic        i_comparator_one_raw,
	input wire logic        o_comparator_one_enable,
	input wire logic        o_comparator_one_positive_select,
	input wire logic        o_comparator_one_negative_select,
	input wire logic        o_comparator_one_control_and_pin,
	input wire logic        o_comparator_one_control_and_pin_oe
);
	import cmp_pkg::*;
	logic [5:0] wd;
	logic       raw_q;
	logic [2:0] steady;
	logic       wr_one;
	logic       rd_one;
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_rst_b);
	// Completed accesses to comparator one
	assign wr_one = o_pready && i_pwrite && i_paddr == CMP_ONE_ADDR;
	assign rd_one = o_pready && !i_pwrite && i_paddr == CMP_ONE_ADDR;
	// Last write data, cycles of steady enabled input
	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			wd     <= 6'h0;
			raw_q  <= 1'h0;
			steady <= 3'h0;
		end else begin
			wd     <= i_pwdata[5:0];
			raw_q  <= i_comparator_one_raw;
			steady <= (i_comparator_one_raw != raw_q || !o_comparator_one_enable) ? 3'h0 : steady + {2'h0, steady != 3'h7};
		end
	end
	fields_a: assert property (wr_one |=> {o_comparator_one_enable, o_comparator_one_positive_select,
		o_comparator_one_negative_select} == wd[5:3]) else $error("control fields wrong");
	pin_gate_a: assert property (wr_one |=> o_comparator_one_control_and_pin_oe == (wd[5] && wd[2]))
		else $error("pin enable wrong");
	oe_enable_a: assert property (o_comparator_one_control_and_pin_oe |-> o_comparator_one_enable)
		else $error("pin driven while off");
	pin_follow_a: assert property (o_comparator_one_control_and_pin_oe |-> o_comparator_one_control_and_pin == i_comparator_one_raw)
		else $error("pin not raw");
	reserved_zero_a: assert property (rd_one |-> o_prdata[7:6] == 2'h0)
		else $error("reserved bits set");
	off_zero_a: assert property (rd_one && !o_comparator_one_enable |-> o_prdata[1:0] == 2'h0)
		else $error("result or flag while off");
	sync_track_a: assert property (rd_one && steady > 3'h5 |-> o_prdata[1] == i_comparator_one_raw)
		else $error("result not tracking");
	irq_mask_a: assert property (o_pready && i_pwrite && i_paddr == IRQ_ENABLE_ADDR && i_pwdata[1:0] == 2'h0 |=> ##1 !o_irq)
		else $error("irq while masked");
endmodule // dual_comparator_control_chk
bind dual_comparator_control dual_comparator_control_chk dual_comparator_control_chk_i (.*);
`default_nettype wire

// file: testbench/tb_dual_comparator_control.sv
`timescale 1ns/1ps
`default_nettype none
module tb_dual_comparator_control;
	import cmp_pkg::*;
	logic        i_clock = 1'h0, i_rst_b = 1'h0, i_psel = 1'h0, i_penable = 1'h0, i_pwrite = 1'h0;
	logic [11:0] i_paddr = 12'h0;
	logic [31:0] i_pwdata = 32'h0, o_prdata, rd;
	logic        o_pready, o_pslverr, o_irq, er;
	wire  [1:0]  raw, en, pos, neg, pin, oe;
	int          va[2], vb[2], vx[2], vr[2], ctl[2], prev[2], flg[2];
	int          ien, n_errors = 0, cmp_count = 0, seed = 32'h9FDB6E8D;
	logic [11:0] map[5] = '{CMP_ONE_ADDR, CMP_TWO_ADDR, IRQ_STATUS_ADDR, IRQ_CLEAR_ADDR, IRQ_ENABLE_ADDR};
	dual_comparator_control #(.SETTLE_COUNT(8)) dual_comparator_control_i (.i_clock, .i_rst_b, .i_psel, .i_penable,
		.i_pwrite, .i_paddr, .i_pwdata, .o_prdata, .o_pready, .o_pslverr, .o_irq,
		.i_comparator_one_raw(raw[0]), .o_comparator_one_enable(en[0]), .o_comparator_one_positive_select(pos[0]),
		.o_comparator_one_negative_select(neg[0]), .o_comparator_one_control_and_pin(pin[0]),
		.o_comparator_one_control_and_pin_oe(oe[0]), .i_comparator_two_raw(raw[1]), .o_comparator_two_enable(en[1]),
		.o_comparator_two_positive_select(pos[1]), .o_comparator_two_negative_select(neg[1]),
		.o_comparator_two_control_and_pin(pin[1]), .o_comparator_two_control_and_pin_oe(oe[1]));
	// Analog cores
	for (genvar c = 0; c < 2; c++) begin : g_core
		cmp_analog_model core_i (.i_clock, .i_enable(en[c]), .i_pos(pos[c]), .i_neg(neg[c]), .i_a(va[c]), .i_b(vb[c]),
			.i_ext(vx[c]), .i_ref(vr[c]), .o_raw(raw[c]));
	end
	always #4 i_clock = ~i_clock;
	task automatic give_verdict;
		if (n_errors == 0 && cmp_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic same(input logic [31:0] got, input logic [31:0] want);
		cmp_count++;
		if (got !== want) begin
			n_errors++;
			$display("BAD %0t got %h want %h", $time, got, want);
		end
	endtask
	// One APB transfer, result left in rd and er
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		i_psel <= 1'h1;
		i_pwrite <= w;
		i_paddr <= a;
		i_pwdata <= d;
		@(posedge i_clock);
		i_penable <= 1'h1;
		do begin
			@(posedge i_clock);
			n++;
		end while (o_pready !== 1'h1 && n < 50);
		if (n == 50) n_errors++;
		rd = o_prdata;
		er = o_pslverr;
		i_psel <= 1'h0;
		i_penable <= 1'h0;
		@(posedge i_clock);
	endtask
	// Reference model of both comparators, then compare
	task automatic expect_state;
		int e[2];
		repeat (12) @(posedge i_clock);
		for (int c = 0; c < 2; c++) begin
			e[c] = ctl[c][5] && ((ctl[c][4] ? vb[c] : va[c]) > (ctl[c][3] ? vr[c] : vx[c]));
			flg[c] = ctl[c][5] && e[c] != prev[c];
			prev[c] = e[c];
			apb(1'h0, c ? CMP_TWO_ADDR : CMP_ONE_ADDR, 32'h0);
			same(rd, {26'h0, ctl[c][5:2], e[c][0], flg[c][0]});
			same({en[c], pos[c], neg[c], oe[c]}, ctl[c][5:2] & {3'h7, ctl[c][5]});
			same({31'h0, pin[c]}, {31'h0, ctl[c][5] && ctl[c][2] && e[c][0]});
		end
		apb(1'h0, IRQ_STATUS_ADDR, 32'h0);
		same(rd, {28'h0, ctl[1][5], ctl[0][5], flg[1][0], flg[0][0]});
		same({31'h0, o_irq}, {31'h0, |({flg[1][0], flg[0][0]} & ien[1:0])});
		apb(1'h1, IRQ_CLEAR_ADDR, 32'h3);
	endtask
	initial begin
		#100000;
		n_errors++;
		give_verdict;
	end
	initial begin
		repeat (4) @(posedge i_clock);
		i_rst_b <= 1'h1;
		@(posedge i_clock);
		apb(1'h1, IRQ_STATUS_ADDR, 32'hF);
		apb(1'h1, 12'h3FC, 32'hFFFFFFFF);
		foreach (map[i]) begin
			apb(1'h0, map[i], 32'h0);
			same(rd, 32'h0);
		end
		apb(1'h0, 12'h3FC, 32'h0);
		same({rd[30:0], er}, 32'h1);
		for (int k = 0; k < 30; k++) begin
			ien = $random(seed) & 3;
			apb(1'h1, IRQ_ENABLE_ADDR, ien);
			apb(1'h0, IRQ_ENABLE_ADDR, 32'h0);
			same(rd, ien);
			for (int c = 0; c < 2; c++) begin
				ctl[c] = $random(seed) & 255;
				apb(1'h1, c ? CMP_TWO_ADDR : CMP_ONE_ADDR, ctl[c]);
			end
			expect_state;
			for (int c = 0; c < 2; c++) begin
				va[c] <= $random(seed) & 3;
				vb[c] <= $random(seed) & 3;
				vx[c] <= $random(seed) & 3;
				vr[c] <= $random(seed) & 3;
			end
			expect_state;
		end
		give_verdict;
	end
endmodule // tb_dual_comparator_control
`default_nettype wire
